// file: inc/seq_defs.svh
// Offsets, field positions, reset values and timing for the power sequencer
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH
`define SQ_LANES 8
`define SQ_ADR_ADV 8'h00
`define SQ_ADR_MSTATE 8'h01
`define SQ_ADR_CTRL 8'h02
`define SQ_ADR_DEINIT 8'h03
`define SQ_ADR_LFLAG 8'h04
`define SQ_ADR_MFLAG 8'h05
`define SQ_ADR_LEN 8'h06
`define SQ_ADR_MEN 8'h07
`define SQ_ADR_TRIG 8'h08
`define SQ_ADR_CRES 8'h09
`define SQ_ADR_INSTANT 8'h0A
`define SQ_ADR_PEND 8'h0B
`define SQ_ADR_TXEN 8'h0C
`define SQ_ADR_RES 8'h0D
`define SQ_ADV_STEP_BIT 6
`define SQ_CTRL_ALLOW_BIT 0
`define SQ_CFG_UNDEF 4'h0
`define SQ_CFG_ACCEPTED 4'h1
`define SQ_CFG_REJECTED 4'h2
`define SQ_CFG_BUSY 4'hC
`define SQ_EN_RST 8'hFF
`define SQ_CLK_MHZ 125
`define SQ_PWRUP_NS 400
`define SQ_PWRDN_NS 400
`define SQ_CFG_NS 200
`define SQ_PWRUP_CYC ((`SQ_PWRUP_NS * `SQ_CLK_MHZ + 999) / 1000)
`define SQ_PWRDN_CYC ((`SQ_PWRDN_NS * `SQ_CLK_MHZ + 999) / 1000)
`define SQ_CFG_CYC ((`SQ_CFG_NS * `SQ_CLK_MHZ + 999) / 1000)
`endif

// file: inc/seq_pkg.sv
// Types shared by the power sequencer modules
`include "seq_defs.svh"
package seq_pkg;
    typedef enum logic [2:0] {
        path_deactivated_state,
        path_init_state,
        path_initialized_state,
        path_tx_turning_on_state,
        path_active_state,
        path_tx_turning_off_state,
        path_deinit_state
    } path_state_t;
    typedef enum logic [1:0] {
        module_low_power_state,
        module_powering_up_state,
        module_ready_state,
        module_powering_down_state
    } mod_state_t;
    typedef struct packed {
        path_state_t st;
        logic tx_en;
        logic res_on;
        logic changed;
    } path_regs_t;
    typedef struct packed {
        logic first;
        logic second;
    } sync_regs_t;
    typedef struct packed {
        mod_state_t mst;
        logic [11:0] mcnt;
        logic low_pwr;
        logic allow;
        logic [`SQ_LANES-1:0] deinit;
        logic [`SQ_LANES-1:0] lflag;
        logic [`SQ_LANES-1:0] len;
        logic mflag;
        logic men;
        logic [`SQ_LANES-1:0] trig;
        logic [`SQ_LANES-1:0] pend;
        logic [3:0] cres;
        logic [11:0] ccnt;
        logic [7:0] rdata;
        logic irq;
    } seq_regs_t;
endpackage

// file: hdl/level_sync.sv
// Two-flop synchroniser for a level from a pin
`timescale 1ns/1ps
module level_sync (
    input wire logic clk_sys, // system clock
    input wire logic sys_rst, // sync reset, high
    input wire logic async_in, // level from outside
    output logic sync_out // synchronised level
);
    seq_pkg::sync_regs_t r;
    seq_pkg::sync_regs_t next_r;

    always_comb begin
        next_r.first = async_in;
        next_r.second = r.first;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign sync_out = r.second;
endmodule

// file: hdl/path_fsm.sv
// State machine of one data path
`timescale 1ns/1ps
module path_fsm (
    input wire logic clk_sys, // system clock
    input wire logic sys_rst, // sync reset, high
    input wire logic deactivate, // deactivate transition
    input wire logic reinit, // pending commissioning
    input wire logic activate_ok, // activation allowed
    output seq_pkg::path_state_t state, // current state
    output logic tx_en, // transmitter enabled
    output logic res_on, // resources held
    output logic changed // pulse on entering active or deactivated
);
    seq_pkg::path_regs_t r;
    seq_pkg::path_regs_t next_r;

    always_comb begin
        next_r = r;
        next_r.changed = 1'b0;
        case (r.st)
            seq_pkg::path_active_state: begin
                if (deactivate || reinit) begin
                    next_r.st = seq_pkg::path_tx_turning_off_state;
                    next_r.tx_en = 1'b0;
                end
            end
            seq_pkg::path_tx_turning_off_state: begin
                next_r.st = seq_pkg::path_initialized_state;
            end
            seq_pkg::path_initialized_state: begin
                if (deactivate || reinit) begin
                    next_r.st = seq_pkg::path_deinit_state;
                    next_r.tx_en = 1'b0;
                    next_r.res_on = 1'b0;
                end else if (activate_ok) begin
                    next_r.st = seq_pkg::path_tx_turning_on_state;
                end
            end
            seq_pkg::path_deinit_state: begin
                next_r.st = seq_pkg::path_deactivated_state;
                next_r.changed = 1'b1;
            end
            seq_pkg::path_deactivated_state: begin
                if (activate_ok) begin
                    next_r.st = seq_pkg::path_init_state;
                    next_r.res_on = 1'b1;
                end
            end
            seq_pkg::path_init_state: begin
                next_r.st = seq_pkg::path_initialized_state;
            end
            seq_pkg::path_tx_turning_on_state: begin
                next_r.st = seq_pkg::path_active_state;
                next_r.tx_en = 1'b1;
                next_r.changed = 1'b1;
            end
            default: begin
                next_r.st = seq_pkg::path_deactivated_state;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign state = r.st;
    assign tx_en = r.tx_en;
    assign res_on = r.res_on;
    assign changed = r.changed;

    property p_tx_off_advances;
        @(posedge clk_sys) disable iff (sys_rst)
        r.st == seq_pkg::path_tx_turning_off_state |=> r.st == seq_pkg::path_initialized_state;
    endproperty
    a_tx_off_advances: assert property (p_tx_off_advances) else $error("tx off stalled");

    property p_redeinit;
        @(posedge clk_sys) disable iff (sys_rst)
        (r.st == seq_pkg::path_initialized_state && (deactivate || reinit))
        |=> r.st == seq_pkg::path_deinit_state;
    endproperty
    a_redeinit: assert property (p_redeinit) else $error("redeinit not taken");

    property p_deinit_dark;
        @(posedge clk_sys) disable iff (sys_rst)
        r.st == seq_pkg::path_deinit_state |-> !r.tx_en && !r.res_on;
    endproperty
    a_deinit_dark: assert property (p_deinit_dark) else $error("deinit path still lit");

    property p_flag_on_deact;
        @(posedge clk_sys) disable iff (sys_rst)
        r.st == seq_pkg::path_deinit_state
        |=> r.st == seq_pkg::path_deactivated_state && r.changed;
    endproperty
    a_flag_on_deact: assert property (p_flag_on_deact) else $error("no change pulse");
endmodule

// file: hdl/datapath_power_sequencer.sv
// Data path deinit, module power-down and config commit sequencer
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "seq_defs.svh"

// Notes on behaviour
// - Pin asserted: software bits decide power
// - Lane deinit bit deactivates its path
// - Tx turning off advances to initialized
// - Redeinit moves initialized paths to deinit
// - Deinit disables tx, releases resources
// - Entering deactivated sets lane flags
// - Reading flags clears them; irq drops unless another enabled flag is set
// - Allow bit moves ready to powering down
// - Powering down reduces power first
// - Entering low power sets module flag
// - Commit writes ignored while config busy
// - Accepted or completed ends commit, clears trigger
// - Default mode ignores commits in transients
// - Default mode: pending mark drives path
// - Stepwise mode: pending never moves path
// - Default mode: instant commit in steady states
// - Stepwise mode: instant commit unsupported
module datapath_power_sequencer #(
    parameter logic STEPWISE_CONFIG_ONLY = 1'b0
) (
    input wire logic clk_sys, // system clock
    input wire logic sys_rst, // sync reset, high
    input wire logic hw_lowpower_request_pin, // low power pin, high
    input wire logic [7:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, next cycle
    output logic irq, // interrupt, high
    output logic [`SQ_LANES-1:0] tx_enable, // per lane transmitter
    output logic module_low_power // reduced power
);
    localparam int L = `SQ_LANES;
    localparam seq_pkg::path_state_t st_act = seq_pkg::path_active_state;
    localparam seq_pkg::path_state_t st_off = seq_pkg::path_tx_turning_off_state;
    localparam seq_pkg::mod_state_t m_low = seq_pkg::module_low_power_state;
    localparam seq_pkg::mod_state_t m_up = seq_pkg::module_powering_up_state;
    localparam seq_pkg::mod_state_t m_rdy = seq_pkg::module_ready_state;
    localparam seq_pkg::mod_state_t m_dn = seq_pkg::module_powering_down_state;

    seq_pkg::seq_regs_t r;
    seq_pkg::seq_regs_t next_r;
    seq_pkg::path_state_t pst [L];
    logic pin_s;
    logic lp_req;
    logic all_deact;
    logic mset;
    logic mclr;
    logic [L-1:0] lclr;
    logic [L-1:0] ptx;
    logic [L-1:0] pres;
    logic [L-1:0] pchg;
    logic [L-1:0] deact;
    logic [L-1:0] act_ok;
    logic [L-1:0] reinit;
    logic [L-1:0] steady;
    logic [L-1:0] isdeact;
    logic [L-1:0] ini;

    function automatic logic is_steady(input seq_pkg::path_state_t s);
        return s == seq_pkg::path_deactivated_state
            || s == seq_pkg::path_initialized_state
            || s == seq_pkg::path_active_state;
    endfunction

    function automatic logic all_steady(input logic [L-1:0] sel, input logic [L-1:0] st);
        return (sel & ~st) == '0;
    endfunction

    // Pin is asynchronous: two flops before any logic reads it
    level_sync u_pin_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .async_in(hw_lowpower_request_pin),
        .sync_out(pin_s)
    );

    genvar g;
    generate
        for (g = 0; g < L; g++) begin : g_path
            path_fsm u_path (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .deactivate(deact[g]),
                .reinit(reinit[g]),
                .activate_ok(act_ok[g]),
                .state(pst[g]),
                .tx_en(ptx[g]),
                .res_on(pres[g]),
                .changed(pchg[g])
            );
            assign steady[g] = is_steady(pst[g]);
            assign isdeact[g] = pst[g] == seq_pkg::path_deactivated_state;
            assign ini[g] = pst[g] == seq_pkg::path_init_state;
        end
    endgenerate

    // Allow bit only counts while the pin asks for low power
    assign lp_req = pin_s & r.allow;
    assign deact = r.deinit | {L{lp_req}};
    // No activation outside ready; host must power up first
    assign act_ok = {L{r.mst == m_rdy}} & ~deact;
    assign reinit = STEPWISE_CONFIG_ONLY ? '0 : (r.pend & steady);
    assign all_deact = &isdeact;

    always_comb begin
        next_r = r;
        next_r.rdata = 8'h00;
        lclr = '0;
        mclr = 1'b0;
        mset = 1'b0;
        if (reg_rd) begin
            if (reg_addr == `SQ_ADR_ADV) begin
                next_r.rdata[`SQ_ADV_STEP_BIT] = STEPWISE_CONFIG_ONLY;
            end else if (reg_addr == `SQ_ADR_MSTATE) begin
                next_r.rdata = {6'h00, r.mst};
            end else if (reg_addr == `SQ_ADR_CTRL) begin
                next_r.rdata[`SQ_CTRL_ALLOW_BIT] = r.allow;
            end else if (reg_addr == `SQ_ADR_DEINIT) begin
                next_r.rdata = r.deinit;
            end else if (reg_addr == `SQ_ADR_LFLAG) begin
                next_r.rdata = r.lflag;
                lclr = r.lflag;
            end else if (reg_addr == `SQ_ADR_MFLAG) begin
                next_r.rdata[0] = r.mflag;
                mclr = r.mflag;
            end else if (reg_addr == `SQ_ADR_LEN) begin
                next_r.rdata = r.len;
            end else if (reg_addr == `SQ_ADR_MEN) begin
                next_r.rdata[0] = r.men;
            end else if (reg_addr == `SQ_ADR_TRIG) begin
                next_r.rdata = r.trig;
            end else if (reg_addr == `SQ_ADR_CRES) begin
                next_r.rdata = {4'h0, r.cres};
            end else if (reg_addr == `SQ_ADR_PEND) begin
                next_r.rdata = r.pend;
            end else if (reg_addr == `SQ_ADR_TXEN) begin
                next_r.rdata = ptx;
            end else if (reg_addr == `SQ_ADR_RES) begin
                next_r.rdata = pres;
            end
        end
        if (reg_wr) begin
            if (reg_addr == `SQ_ADR_CTRL) begin
                next_r.allow = reg_wdata[`SQ_CTRL_ALLOW_BIT];
            end else if (reg_addr == `SQ_ADR_DEINIT) begin
                next_r.deinit = reg_wdata;
            end else if (reg_addr == `SQ_ADR_LFLAG) begin
                lclr = reg_wdata;
            end else if (reg_addr == `SQ_ADR_MFLAG) begin
                mclr = reg_wdata[0];
            end else if (reg_addr == `SQ_ADR_LEN) begin
                next_r.len = reg_wdata;
            end else if (reg_addr == `SQ_ADR_MEN) begin
                next_r.men = reg_wdata[0];
            end else if (reg_addr == `SQ_ADR_TRIG && r.cres != `SQ_CFG_BUSY) begin
                if (STEPWISE_CONFIG_ONLY || all_steady(reg_wdata, steady)) begin
                    next_r.trig = reg_wdata;
                    next_r.cres = `SQ_CFG_BUSY;
                    next_r.ccnt = 12'(`SQ_CFG_CYC);
                end
            // Instant commit only reports a result; nothing else is applied
            end else if (reg_addr == `SQ_ADR_INSTANT && r.cres != `SQ_CFG_BUSY) begin
                if (STEPWISE_CONFIG_ONLY) begin
                    next_r.cres = `SQ_CFG_REJECTED;
                end else if (all_steady(reg_wdata, steady)) begin
                    next_r.cres = `SQ_CFG_ACCEPTED;
                end else begin
                    next_r.cres = `SQ_CFG_REJECTED;
                end
            end
        end

        // Pending marks are consumed when their path initialises
        next_r.pend = r.pend & ~ini;
        if (r.cres == `SQ_CFG_BUSY) begin
            if (r.ccnt != 12'h000) begin
                next_r.ccnt = r.ccnt - 12'h001;
            end else begin
                next_r.cres = `SQ_CFG_ACCEPTED;
                next_r.pend = next_r.pend | r.trig;
                next_r.trig = '0;
            end
        end

        // Low power is left as soon as either the allow bit or the pin drops
        case (r.mst)
            seq_pkg::module_low_power_state: begin
                if (!lp_req) begin
                    next_r.mst = m_up;
                    next_r.mcnt = 12'(`SQ_PWRUP_CYC);
                end
            end
            seq_pkg::module_powering_up_state: begin
                if (r.mcnt != 12'h000) begin
                    next_r.mcnt = r.mcnt - 12'h001;
                end else begin
                    next_r.mst = m_rdy;
                    next_r.low_pwr = 1'b0;
                    mset = 1'b1;
                end
            end
            seq_pkg::module_ready_state: begin
                if (lp_req && all_deact) begin
                    next_r.mst = m_dn;
                    next_r.mcnt = 12'(`SQ_PWRDN_CYC);
                    next_r.low_pwr = 1'b1;
                end
            end
            default: begin
                if (r.mcnt != 12'h000) begin
                    next_r.mcnt = r.mcnt - 12'h001;
                end else begin
                    next_r.mst = m_low;
                    mset = 1'b1;
                end
            end
        endcase

        // A new event beats a clear in the same cycle
        next_r.lflag = (r.lflag & ~lclr) | pchg;
        next_r.mflag = (r.mflag & ~mclr) | mset;
        next_r.irq = |(next_r.lflag & next_r.len) | (next_r.mflag & next_r.men);
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            // Wake in low power with every flag enabled
            r <= '0;
            r.mst <= m_low;
            r.low_pwr <= 1'b1;
            r.len <= `SQ_EN_RST;
            r.men <= 1'b1;
            r.cres <= `SQ_CFG_UNDEF;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata = r.rdata;
    assign irq = r.irq;
    assign tx_enable = ptx;
    assign module_low_power = r.low_pwr;

    property p_pin_gates;
        @(posedge clk_sys) disable iff (sys_rst)
        (!pin_s && r.mst == m_rdy) |=> r.mst != m_dn;
    endproperty
    a_pin_gates: assert property (p_pin_gates) else $error("powered down without pin");

    property p_deinit_starts;
        @(posedge clk_sys) disable iff (sys_rst)
        (r.deinit[0] && pst[0] == st_act) |=> pst[0] == st_off;
    endproperty
    a_deinit_starts: assert property (p_deinit_starts) else $error("deinit ignored");

    property p_read_clears;
        @(posedge clk_sys) disable iff (sys_rst)
        (reg_rd && reg_addr == `SQ_ADR_LFLAG) |=> (r.lflag & $past(r.lflag) & ~$past(pchg)) == '0;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("flag read did not clear");

    property p_allow_powers_down;
        @(posedge clk_sys) disable iff (sys_rst)
        (r.mst == m_rdy && lp_req && all_deact) |=> r.mst == m_dn && r.low_pwr;
    endproperty
    a_allow_powers_down: assert property (p_allow_powers_down) else $error("no power down");

    property p_power_reduced;
        @(posedge clk_sys) disable iff (sys_rst)
        (r.mst == m_rdy ##1 r.mst == m_dn) |-> (r.mst == m_dn && r.low_pwr)[*8];
    endproperty
    a_power_reduced: assert property (p_power_reduced) else $error("power down cut short");

    property p_low_flag;
        @(posedge clk_sys) disable iff (sys_rst)
        (r.mst == m_dn ##1 r.mst == m_low) |-> r.mflag;
    endproperty
    a_low_flag: assert property (p_low_flag) else $error("module flag not set");

    property p_busy_ignores;
        @(posedge clk_sys) disable iff (sys_rst)
        (reg_wr && reg_addr == `SQ_ADR_TRIG && r.cres == `SQ_CFG_BUSY && r.ccnt != 12'h000)
        |=> r.trig == $past(r.trig);
    endproperty
    a_busy_ignores: assert property (p_busy_ignores) else $error("busy commit taken");

    property p_commit_ends;
        @(posedge clk_sys) disable iff (sys_rst)
        (r.cres == `SQ_CFG_BUSY && r.ccnt == 12'h000)
        |=> r.cres == `SQ_CFG_ACCEPTED && r.trig == '0;
    endproperty
    a_commit_ends: assert property (p_commit_ends) else $error("commit did not end");

    property p_transient_ignores;
        @(posedge clk_sys) disable iff (sys_rst)
        (!STEPWISE_CONFIG_ONLY && reg_wr && reg_addr == `SQ_ADR_TRIG
            && r.cres != `SQ_CFG_BUSY && !all_steady(reg_wdata, steady))
        |=> r.cres == $past(r.cres);
    endproperty
    a_transient_ignores: assert property (p_transient_ignores) else $error("transient commit");

    property p_pending_drives;
        @(posedge clk_sys) disable iff (sys_rst)
        (!STEPWISE_CONFIG_ONLY && r.pend[0] && pst[0] == st_act) |=> pst[0] == st_off;
    endproperty
    a_pending_drives: assert property (p_pending_drives) else $error("pending ignored");

    property p_stepwise_quiet;
        @(posedge clk_sys) disable iff (sys_rst)
        (STEPWISE_CONFIG_ONLY && pst[0] == st_act && !deact[0]) |=> pst[0] == st_act;
    endproperty
    a_stepwise_quiet: assert property (p_stepwise_quiet) else $error("stepwise path moved");

    property p_instant_ok;
        @(posedge clk_sys) disable iff (sys_rst)
        (!STEPWISE_CONFIG_ONLY && reg_wr && reg_addr == `SQ_ADR_INSTANT
            && r.cres != `SQ_CFG_BUSY && all_steady(reg_wdata, steady))
        |=> r.cres == `SQ_CFG_ACCEPTED;
    endproperty
    a_instant_ok: assert property (p_instant_ok) else $error("instant commit refused");

    property p_instant_refused;
        @(posedge clk_sys) disable iff (sys_rst)
        (STEPWISE_CONFIG_ONLY && reg_wr && reg_addr == `SQ_ADR_INSTANT
            && r.cres != `SQ_CFG_BUSY) |=> r.cres == `SQ_CFG_REJECTED;
    endproperty
    a_instant_refused: assert property (p_instant_refused) else $error("instant accepted");

    property p_irq_level;
        @(posedge clk_sys) disable iff (sys_rst)
        r.irq == (|(r.lflag & r.len) | (r.mflag & r.men));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq disagrees with flags");
endmodule

// file: bench/host_model.sv
// Host controller model: register bus master and low power pin driver
`timescale 1ns/1ps
module host_model (
    input wire logic clk_sys, // system clock
    output logic [7:0] reg_addr, // register address
    output logic [7:0] reg_wdata, // write data
    output logic reg_wr, // write strobe
    output logic reg_rd, // read strobe
    output logic pin, // low power pin
    input wire logic [7:0] rdata_a, // read data, default mode
    input wire logic [7:0] rdata_b // read data, stepwise mode
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        pin = 1'b0;
    end
    // Deinit, allow and power-up writes all go through here
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Register reads; data stands one cycle only
    task automatic rd(input logic [7:0] a, output logic [7:0] da, output logic [7:0] db);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        da = rdata_a;
        db = rdata_b;
    endtask
    task automatic set_pin(input logic v);
        @(posedge clk_sys);
        pin <= v;
    endtask
endmodule

// file: bench/tb_datapath_power_sequencer.sv
// Bench for the sequencer: default and stepwise instances on one bus
`timescale 1ns/1ps
`include "seq_defs.svh"
module tb_datapath_power_sequencer;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr, reg_wdata, rdata_a, rdata_b, tx_a, tx_b, ra, rb;
    logic reg_wr, reg_rd, pin, irq_a, irq_b, lp_a, lp_b;
    int n_fail = 0;
    int n_compared = 0;
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    host_model i_host_model (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .pin(pin), .rdata_a(rdata_a), .rdata_b(rdata_b));
    datapath_power_sequencer #(.STEPWISE_CONFIG_ONLY(1'b0)) i_datapath_power_sequencer (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .hw_lowpower_request_pin(pin),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(rdata_a), .irq(irq_a), .tx_enable(tx_a), .module_low_power(lp_a));
    // Shares every input, so the two modes can be told apart read by read
    datapath_power_sequencer #(.STEPWISE_CONFIG_ONLY(1'b1)) i_datapath_power_sequencer_step (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .hw_lowpower_request_pin(pin),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(rdata_b), .irq(irq_b), .tx_enable(tx_b), .module_low_power(lp_b));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rc(input string what, input logic [7:0] a, input logic [7:0] ea,
            input logic [7:0] eb);
        i_host_model.rd(a, ra, rb);
        chk(what, ea, ra);
        chk({what, " stepwise"}, eb, rb);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic end_of_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_fail++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1;
        chk("tx reset", 8'h00, tx_a);
        chk("low power reset", 8'h01, {7'h00, lp_a});
        rc("adv", `SQ_ADR_ADV, 8'h00, 8'h40);
        rc("lane enables", `SQ_ADR_LEN, 8'hFF, 8'hFF);
        rc("unmapped", 8'h20, 8'h00, 8'h00);
        cyc(70);
        rc("mstate up", `SQ_ADR_MSTATE, 8'h02, 8'h02);
        rc("lane flags up", `SQ_ADR_LFLAG, 8'hFF, 8'hFF);
        chk("irq module flag left", 8'h01, {7'h00, irq_a});
        i_host_model.wr(`SQ_ADR_MFLAG, 8'h01);
        cyc(2);
        chk("irq write clear", 8'h00, {7'h00, irq_a});
        i_host_model.set_pin(1'b1);
        cyc(5);
        rc("mstate pin high", `SQ_ADR_MSTATE, 8'h02, 8'h02);
        chk("tx pin high", 8'hFF, tx_a);
        i_host_model.wr(`SQ_ADR_DEINIT, 8'hFF);
        i_host_model.wr(`SQ_ADR_TRIG, 8'h01);
        rc("cres transient", `SQ_ADR_CRES, `SQ_CFG_UNDEF, `SQ_CFG_BUSY);
        cyc(8);
        chk("tx deinit", 8'h00, tx_a);
        rc("resources", `SQ_ADR_RES, 8'h00, 8'h00);
        chk("irq deact", 8'h01, {7'h00, irq_a});
        chk("irq deact stepwise", 8'h01, {7'h00, irq_b});
        rc("lane flags deact", `SQ_ADR_LFLAG, 8'hFF, 8'hFF);
        chk("irq read clear", 8'h00, {7'h00, irq_a});
        i_host_model.wr(`SQ_ADR_MEN, 8'h00);
        i_host_model.wr(`SQ_ADR_CTRL, 8'h01);
        cyc(3);
        rc("mstate down", `SQ_ADR_MSTATE, 8'h03, 8'h03);
        chk("low power down", 8'h01, {7'h00, lp_a});
        chk("low power down stepwise", 8'h01, {7'h00, lp_b});
        cyc(55);
        rc("mstate low", `SQ_ADR_MSTATE, 8'h00, 8'h00);
        chk("irq masked", 8'h00, {7'h00, irq_a});
        i_host_model.wr(`SQ_ADR_MEN, 8'h01);
        cyc(2);
        chk("irq unmasked", 8'h01, {7'h00, irq_a});
        rc("module flag", `SQ_ADR_MFLAG, 8'h01, 8'h01);
        chk("irq module clear", 8'h00, {7'h00, irq_a});
        i_host_model.wr(`SQ_ADR_CTRL, 8'h00);
        i_host_model.wr(`SQ_ADR_DEINIT, 8'h00);
        cyc(70);
        rc("mstate back", `SQ_ADR_MSTATE, 8'h02, 8'h02);
        chk("tx back", 8'hFF, tx_a);
        i_host_model.wr(`SQ_ADR_LFLAG, 8'h0F);
        rc("lane flags back", `SQ_ADR_LFLAG, 8'hF0, 8'hF0);
        rc("module flag back", `SQ_ADR_MFLAG, 8'h01, 8'h01);
        i_host_model.wr(`SQ_ADR_INSTANT, 8'hFF);
        rc("instant", `SQ_ADR_CRES, `SQ_CFG_ACCEPTED, `SQ_CFG_REJECTED);
        i_host_model.wr(`SQ_ADR_TRIG, 8'h01);
        rc("cres busy", `SQ_ADR_CRES, `SQ_CFG_BUSY, `SQ_CFG_BUSY);
        i_host_model.wr(`SQ_ADR_TRIG, 8'h02);
        rc("trig held", `SQ_ADR_TRIG, 8'h01, 8'h01);
        i_host_model.wr(`SQ_ADR_INSTANT, 8'hFF);
        rc("cres still busy", `SQ_ADR_CRES, `SQ_CFG_BUSY, `SQ_CFG_BUSY);
        cyc(30);
        rc("cres done", `SQ_ADR_CRES, `SQ_CFG_ACCEPTED, `SQ_CFG_ACCEPTED);
        rc("trig cleared", `SQ_ADR_TRIG, 8'h00, 8'h00);
        cyc(10);
        rc("restart flags", `SQ_ADR_LFLAG, 8'h01, 8'h00);
        rc("pending", `SQ_ADR_PEND, 8'h00, 8'h01);
        chk("tx after restart", 8'hFF, tx_a);
        chk("tx stepwise untouched", 8'hFF, tx_b);
        end_of_test();
    end
endmodule
